// *** rtl/dct_pkg.sv ***
// Function
// - Counter function adds one per falling edge on the event pin.
// - Events up to a quarter of the system clock rate are counted.
// - Each timer count is 16 bits, reached as low and high bytes.
// - 13-bit mode: high byte plus low bits 4..0; low bits 7..5 idle.
// - 13-bit rollover from all ones sets the overflow flag.
// - Counter-select picks event pin edges or the internal clock.
// - Clock-select picks system clock, else the prescaled clock.
// - Count only with run set and gate off or gate input active.
// - Setting run keeps the count; counting resumes from it.
// - Timer 1 mirrors timer 0 with its own bits and gate polarity.
// - 16-bit mode uses all sixteen count bits.
// - Auto-reload: low byte counts, overflow sets flag, reloads from high.
// - Split mode: timer 0 low byte uses timer 0 controls and flag.
// - Split mode: timer 0 high byte times clocks, run by timer 1 run.
// - Timer 0 split: timer 1 no events, no flag, overflow still out.
// - Timer 1 mode 3 stops it; while split its mode is its run.
// - Overflow interrupt only when that timer's enable bit is set.
// - Mode codes: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split.
// - Prescale: 00 div 12, 01 div 4, 10 div 48, 11 external div 8.
// - Flag clears on interrupt vector, or by software write.
package dct_pkg;
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_CLK     = 8'h08;
	localparam logic [7:0] OFS_T0_LOW  = 8'h0C;
	localparam logic [7:0] OFS_T1_LOW  = 8'h10;
	localparam logic [7:0] OFS_T0_HIGH = 8'h14;
	localparam logic [7:0] OFS_T1_HIGH = 8'h18;
	localparam logic [7:0] OFS_GATEPOL = 8'h1C;
	localparam logic [7:0] OFS_IRQEN   = 8'h20;
	// Control register bits
	localparam int B_TF1 = 7;
	localparam int B_TR1 = 6;
	localparam int B_TF0 = 5;
	localparam int B_TR0 = 4;
	// Mode register bits
	localparam int B_TIMER1_GATE_ENABLE = 7;
	localparam int B_CT1   = 6;
	localparam int B_M1_LO = 4;
	localparam int B_TIMER0_GATE_ENABLE = 3;
	localparam int B_CT0   = 2;
	localparam int B_M0_LO = 0;
	// Clock control bits
	localparam int B_T1M   = 3;
	localparam int B_T0M   = 2;
	localparam int B_SC_LO = 0;
	// Mode codes
	localparam logic [1:0] MODE_13  = 2'h0;
	localparam logic [1:0] MODE_16  = 2'h1;
	localparam logic [1:0] MODE_8AR = 2'h2;
	localparam logic [1:0] MODE_SPL = 2'h3;
	// Prescale codes and divisors
	localparam logic [1:0] SC_DIV12 = 2'h0;
	localparam logic [1:0] SC_DIV4  = 2'h1;
	localparam logic [1:0] SC_DIV48 = 2'h2;
	localparam logic [1:0] SC_EXT8  = 2'h3;
	localparam logic [5:0] DIV12_LAST = 6'h0B;
	localparam logic [5:0] DIV4_LAST  = 6'h03;
	localparam logic [5:0] DIV48_LAST = 6'h2F;
	localparam logic [2:0] EXT8_LAST  = 3'h7;
	localparam logic [7:0]  REG_RESET = 8'h00;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [12:0] ONE13 = 13'h0001;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [7:0]  ONE8  = 8'h01;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       ovf;
	} dct_cnt_s;
endpackage

// *** rtl/dct_timers.sv ***
`timescale 1ns/1ns
`default_nettype none
module dct_timers
	import dct_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic [31:0]      hrdata_o,
	output logic             hresp_o,
	// Pins
	input  wire logic        event_pin_0_i,
	input  wire logic        event_pin_1_i,
	input  wire logic        external_gate_input_0_i,
	input  wire logic        external_gate_input_1_i,
	input  wire logic        ext_clk_i,
	// Interrupt vector acknowledge
	input  wire logic        irq0_ack_i,
	input  wire logic        irq1_ack_i,
	// Requests and overflow
	output logic             irq0_o,
	output logic             irq1_o,
	output logic             timer1_ovf_o
);
	// Register state
	logic [7:0] timer_control_register;
	logic [7:0] timer_mode_register;
	logic [7:0] clock_control_register;
	logic [7:0] timer0_low_byte, timer0_high_byte;
	logic [7:0] timer1_low_byte, timer1_high_byte;
	logic [1:0] gate_polarity;
	logic [1:0] irq_enable;
	logic       wr_q;
	logic [7:0] addr_q;
	logic [7:0] next_ctrl, next_mode, next_clk;
	logic [7:0] next_t0_low, next_t0_high, next_t1_low, next_t1_high;
	logic [1:0] next_gpol, next_irqen;
	logic [31:0] next_rdata;

	// Input samplers: two stages then a history stage
	logic [4:0] sync1, sync2, hist;
	logic [4:0] pins;
	assign pins = {ext_clk_i, external_gate_input_1_i,
		external_gate_input_0_i, event_pin_1_i, event_pin_0_i};
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
			hist  <= '0;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
			hist  <= sync2;
		end
	end
	logic fall0, fall1, ext_rise;
	assign fall0    = hist[0] & ~sync2[0];
	assign fall1    = hist[1] & ~sync2[1];
	assign ext_rise = ~hist[4] & sync2[4];

	// Prescaler
	logic [5:0] pre_cnt;
	logic [2:0] ext_cnt;
	logic [1:0] scale;
	logic [5:0] pre_last;
	logic       pre_wrap, ext_wrap, pre_tick;
	assign scale    = clock_control_register[B_SC_LO +: 2];
	assign pre_last = (scale == SC_DIV4)  ? DIV4_LAST :
	                  (scale == SC_DIV48) ? DIV48_LAST : DIV12_LAST;
	assign pre_wrap = (pre_cnt >= pre_last);
	assign ext_wrap = ext_rise && (ext_cnt == EXT8_LAST);
	assign pre_tick = (scale == SC_EXT8) ? ext_wrap : pre_wrap;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_cnt <= '0;
			ext_cnt <= '0;
		end else begin
			pre_cnt <= pre_wrap ? '0 : pre_cnt + 6'h01;
			ext_cnt <= ext_rise ? ext_cnt + 3'h1 : ext_cnt;
		end
	end

	// One count step of a timer in the given mode
	function automatic dct_cnt_s tmr_step(input logic [1:0] mode,
		input logic [7:0] lo, input logic [7:0] hi, input logic inc);
		dct_cnt_s r;
		logic [12:0] v13;
		logic [15:0] v16;
		r   = '{low: lo, high: hi, ovf: 1'b0};
		v13 = {hi, lo[4:0]} + ONE13;
		v16 = {hi, lo} + ONE16;
		if (inc) begin
			unique case (mode)
				MODE_13: begin
					r.high = v13[12:5];
					r.low  = {lo[7:5], v13[4:0]};
					r.ovf  = &{hi, lo[4:0]};
				end
				MODE_16: begin
					{r.high, r.low} = v16;
					r.ovf = &{hi, lo};
				end
				MODE_8AR: begin
					r.ovf = &lo;
					r.low = r.ovf ? hi : lo + ONE8;
				end
				MODE_SPL: begin
					r.low = lo + ONE8;
					r.ovf = &lo;
				end
			endcase
		end
		return r;
	endfunction

	// Count enables
	logic [1:0] mode0, mode1;
	logic       tr0, tr1, split, en0, en1, src0, src1, inc0, inc1, inc0h;
	logic       tick0, tick1;
	assign mode0 = timer_mode_register[B_M0_LO +: 2];
	assign mode1 = timer_mode_register[B_M1_LO +: 2];
	assign tr0   = timer_control_register[B_TR0];
	assign tr1   = timer_control_register[B_TR1];
	assign split = (mode0 == MODE_SPL);
	assign tick0 = clock_control_register[B_T0M] | pre_tick;
	assign tick1 = clock_control_register[B_T1M] | pre_tick;
	assign en0   = tr0 & (~timer_mode_register[B_TIMER0_GATE_ENABLE] |
		(sync2[2] == gate_polarity[0]));
	assign en1   = tr1 & (~timer_mode_register[B_TIMER1_GATE_ENABLE] |
		(sync2[3] == gate_polarity[1]));
	assign src0  = timer_mode_register[B_CT0] ? fall0 : tick0;
	assign src1  = timer_mode_register[B_CT1] ? fall1 : tick1;
	assign inc0  = en0 & src0;
	assign inc1  = (mode1 != MODE_SPL) &
		(split ? tick1 : (en1 & src1));
	assign inc0h = split & tr1 & tick0;

	dct_cnt_s st0, st1;
	assign st0 = tmr_step(mode0, timer0_low_byte, timer0_high_byte, inc0);
	assign st1 = tmr_step(mode1, timer1_low_byte, timer1_high_byte, inc1);
	logic       ovf0h;
	logic [7:0] hi0_split;
	assign ovf0h     = inc0h & (&timer0_high_byte);
	assign hi0_split = inc0h ? timer0_high_byte + ONE8 : timer0_high_byte;

	// Bus decode
	logic addr_ok;
	logic [7:0] wbyte;
	assign addr_ok = hsel_i && hready_i && htrans_i[1];
	assign wbyte   = hwdata_i[7:0];
	function automatic logic wr_at(input logic [7:0] ofs, input logic w,
		input logic [7:0] a);
		return w && (a == ofs);
	endfunction

	logic set_tf0, set_tf1, clr_tf0, clr_tf1, ctrl_wr;
	assign ctrl_wr = wr_at(OFS_CTRL, wr_q, addr_q);
	assign set_tf0 = st0.ovf;
	assign set_tf1 = split ? ovf0h : st1.ovf;
	assign clr_tf0 = ctrl_wr ? ~wbyte[B_TF0] : irq0_ack_i;
	assign clr_tf1 = ctrl_wr ? ~wbyte[B_TF1] : irq1_ack_i;

	always_comb begin
		next_ctrl = ctrl_wr ? wbyte : timer_control_register;
		next_ctrl[B_TF0] = set_tf0 |
			(timer_control_register[B_TF0] & ~clr_tf0);
		next_ctrl[B_TF1] = set_tf1 |
			(timer_control_register[B_TF1] & ~clr_tf1);
		if (ctrl_wr) begin
			next_ctrl[B_TF0] = set_tf0 | wbyte[B_TF0];
			next_ctrl[B_TF1] = set_tf1 | wbyte[B_TF1];
		end
	end
	assign next_mode  = wr_at(OFS_MODE, wr_q, addr_q) ? wbyte :
		timer_mode_register;
	assign next_clk   = wr_at(OFS_CLK, wr_q, addr_q) ? wbyte :
		clock_control_register;
	assign next_gpol  = wr_at(OFS_GATEPOL, wr_q, addr_q) ? wbyte[1:0] :
		gate_polarity;
	assign next_irqen = wr_at(OFS_IRQEN, wr_q, addr_q) ? wbyte[1:0] :
		irq_enable;
	assign next_t0_low  = wr_at(OFS_T0_LOW, wr_q, addr_q) ? wbyte :
		st0.low;
	assign next_t0_high = wr_at(OFS_T0_HIGH, wr_q, addr_q) ? wbyte :
		(split ? hi0_split : st0.high);
	assign next_t1_low  = wr_at(OFS_T1_LOW, wr_q, addr_q) ? wbyte :
		st1.low;
	assign next_t1_high = wr_at(OFS_T1_HIGH, wr_q, addr_q) ? wbyte :
		st1.high;

	// Read data from the post-write state so a read right after a write
	// sees the written value
	logic [7:0] raddr;
	assign raddr = haddr_i[7:0];
	assign next_rdata =
		(haddr_i[31:8] != '0)   ? RDATA_ZERO :
		(raddr == OFS_CTRL)     ? {24'h0, next_ctrl} :
		(raddr == OFS_MODE)     ? {24'h0, next_mode} :
		(raddr == OFS_CLK)      ? {24'h0, next_clk} :
		(raddr == OFS_T0_LOW)   ? {24'h0, next_t0_low} :
		(raddr == OFS_T1_LOW)   ? {24'h0, next_t1_low} :
		(raddr == OFS_T0_HIGH)  ? {24'h0, next_t0_high} :
		(raddr == OFS_T1_HIGH)  ? {24'h0, next_t1_high} :
		(raddr == OFS_GATEPOL)  ? {30'h0, next_gpol} :
		(raddr == OFS_IRQEN)    ? {30'h0, next_irqen} : RDATA_ZERO;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q     <= 1'b0;
			addr_q   <= '0;
			hrdata_o <= RDATA_ZERO;
		end else begin
			// Writes outside the mapped page are dropped
			wr_q   <= addr_ok & hwrite_i & (haddr_i[31:8] == '0);
			addr_q <= (haddr_i[31:8] == '0) ? raddr : REG_RESET;
			if (addr_ok && !hwrite_i) begin
				hrdata_o <= next_rdata;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_control_register <= REG_RESET;
			timer_mode_register    <= REG_RESET;
			clock_control_register <= REG_RESET;
			timer0_low_byte        <= REG_RESET;
			timer0_high_byte       <= REG_RESET;
			timer1_low_byte        <= REG_RESET;
			timer1_high_byte       <= REG_RESET;
			gate_polarity          <= '0;
			irq_enable             <= '0;
		end else begin
			timer_control_register <= next_ctrl;
			timer_mode_register    <= next_mode;
			clock_control_register <= next_clk;
			timer0_low_byte        <= next_t0_low;
			timer0_high_byte       <= next_t0_high;
			timer1_low_byte        <= next_t1_low;
			timer1_high_byte       <= next_t1_high;
			gate_polarity          <= next_gpol;
			irq_enable             <= next_irqen;
		end
	end

	// Outputs from flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hreadyout_o  <= 1'b1;
			hresp_o      <= 1'b0;
			irq0_o       <= 1'b0;
			irq1_o       <= 1'b0;
			timer1_ovf_o <= 1'b0;
		end else begin
			hreadyout_o  <= 1'b1;
			hresp_o      <= 1'b0;
			irq0_o       <= next_ctrl[B_TF0] & next_irqen[0];
			irq1_o       <= next_ctrl[B_TF1] & next_irqen[1];
			timer1_ovf_o <= st1.ovf;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic quiet_t0, quiet_t1;
	assign quiet_t0 = !(wr_q && (addr_q == OFS_T0_LOW ||
		addr_q == OFS_T0_HIGH || addr_q == OFS_MODE));
	assign quiet_t1 = !(wr_q && (addr_q == OFS_T1_LOW ||
		addr_q == OFS_T1_HIGH || addr_q == OFS_MODE));

	a_tf0_on_ovf: assert property (set_tf0 |=>
		timer_control_register[B_TF0] ##1 irq0_o == irq_enable[0])
		else $error("timer0 flag not set on overflow");
	a_edge_single: assert property (fall0 |=> !fall0)
		else $error("edge pulse longer than one cycle");
	a_event_count: assert property (tr0 && !timer_mode_register[B_TIMER0_GATE_ENABLE]
		&& timer_mode_register[B_CT0] && mode0 == MODE_16 && fall0
		&& quiet_t0 |=> {timer0_high_byte, timer0_low_byte} ==
		$past({timer0_high_byte, timer0_low_byte}) + ONE16)
		else $error("event edge not counted");
	a_stop_hold: assert property (!tr0 && quiet_t0 && !split
		|=> $stable({timer0_high_byte, timer0_low_byte}))
		else $error("stopped timer0 changed");
	a_auto_reload: assert property (mode0 == MODE_8AR && inc0 &&
		(&timer0_low_byte) && quiet_t0 |=> timer0_low_byte ==
		$past(timer0_high_byte) && $stable(timer0_high_byte))
		else $error("auto reload wrong");
	a_split_tf1: assert property (split && tr1 && (&timer0_high_byte)
		&& clock_control_register[B_T0M] && !ctrl_wr
		|=> timer_control_register[B_TF1])
		else $error("split high byte overflow lost");
	a_t1_mode3: assert property (mode1 == MODE_SPL && quiet_t1
		|=> $stable({timer1_high_byte, timer1_low_byte}))
		else $error("timer1 runs in mode 3");
	a_ack_clear: assert property (irq0_ack_i && !set_tf0 && !ctrl_wr
		|=> !timer_control_register[B_TF0] ##1 !irq0_o)
		else $error("vector acknowledge did not clear flag");
	a_irq_mask: assert property (!irq_enable[1] && !next_irqen[1]
		|=> !irq1_o)
		else $error("masked interrupt raised");
	a_split_noflag: assert property (split && st1.ovf && !ovf0h
		&& !ctrl_wr |=> timer_control_register[B_TF1] ==
		$past(timer_control_register[B_TF1]))
		else $error("timer1 set flag while split");

	c_reload: cover property (mode0 == MODE_8AR && set_tf0);
	c_split_ovf: cover property (split && ovf0h);
	c_event: cover property (timer_mode_register[B_CT1] && inc1);
endmodule // dct_timers
`default_nettype wire

// *** verif/dct_pins_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dct_pins_model (
	// Clock
	input  wire logic clk_i,
	// Pins toward the timers
	output logic      event_0_o,
	output logic      event_1_o,
	output logic      gate_0_o,
	output logic      gate_1_o,
	output logic      ext_clk_o
);
	initial begin
		event_0_o = 1'b1;
		event_1_o = 1'b1;
		gate_0_o  = 1'b0;
		gate_1_o  = 1'b1;
		ext_clk_o = 1'b0;
	end
	// Free-running external clock
	always @(posedge clk_i) begin
		ext_clk_o <= ~ext_clk_o;
	end
	// One falling edge, low held two clocks, then high: back-to-back pulses repeat every five clocks
	task automatic pulse(input logic sel);
		@(posedge clk_i);
		if (sel) event_1_o <= 1'b0;
		else event_0_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		event_0_o <= 1'b1;
		event_1_o <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic gate(input logic sel, input logic lvl);
		@(posedge clk_i);
		if (sel) gate_1_o <= lvl;
		else gate_0_o <= lvl;
	endtask
endmodule // dct_pins_model
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dct_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        ack0 = 1'b0;
	logic        ack1 = 1'b0;
	wire logic   hrdy;
	wire logic   hresp;
	wire logic   irq0;
	wire logic   irq1;
	wire logic   ev0, ev1, g0, g1, xclk;
	wire logic   t1ovf;
	int          t1_ovf_seen = 0;
	int          ovf_base = 0;
	logic [31:0] hrdata;
	int          err_total = 0;
	int          total_checks = 0;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (t1ovf === 1'b1) t1_ovf_seen++;
	end
	dct_pins_model u_dct_pins_model (.clk_i(clk_i), .event_0_o(ev0),
		.event_1_o(ev1), .gate_0_o(g0), .gate_1_o(g1), .ext_clk_o(xclk));
	dct_timers u_dct_timers (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hrdy), .hreadyout_o(hrdy), .hrdata_o(hrdata),
		.hresp_o(hresp), .event_pin_0_i(ev0), .event_pin_1_i(ev1),
		.external_gate_input_0_i(g0), .external_gate_input_1_i(g1),
		.ext_clk_i(xclk), .irq0_ack_i(ack0), .irq1_ack_i(ack1),
		.irq0_o(irq0), .irq1_o(irq1), .timer1_ovf_o(t1ovf));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One AHB-Lite single transfer; read data taken at data-phase end
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, a, {24'h000000, d}, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp);
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x & m, exp);
	endtask
	task automatic ev(input logic sel, input int n);
		repeat (n) u_dct_pins_model.pulse(sel);
		repeat (6) @(posedge clk_i);
	endtask
	initial begin
		#(100 * 20000);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_MODE, 32'h0);
		rd(OFS_T0_HIGH, 32'h0);
		wr(8'h40, 8'h5A);
		rd(8'h40, 32'h0);
		// 13-bit event count through rollover
		wr(OFS_T0_HIGH, 8'hFF);
		wr(OFS_T0_LOW, 8'hFE);
		wr(OFS_MODE, 8'h04);
		wr(OFS_CTRL, 8'h10);
		ev(1'b0, 1);
		rd(OFS_CTRL, 32'h10);
		rdm(OFS_T0_LOW, 32'h1F, 32'h1F);
		ev(1'b0, 1);
		rdm(OFS_T0_LOW, 32'h1F, 32'h00);
		rd(OFS_T0_HIGH, 32'h00);
		rd(OFS_CTRL, 32'h30);
		// Stop and restart keeps the count
		wr(OFS_CTRL, 8'h00);
		ev(1'b0, 1);
		wr(OFS_CTRL, 8'h10);
		ev(1'b0, 1);
		rdm(OFS_T0_LOW, 32'h1F, 32'h01);
		// 16-bit mode with gate, active-high polarity
		wr(OFS_CTRL, 8'h00);
		wr(OFS_T0_LOW, 8'hFF);
		wr(OFS_T0_HIGH, 8'h00);
		wr(OFS_GATEPOL, 8'h01);
		wr(OFS_MODE, 8'h0D);
		wr(OFS_CTRL, 8'h10);
		ev(1'b0, 2);
		rd(OFS_T0_LOW, 32'hFF);
		u_dct_pins_model.gate(1'b0, 1'b1);
		ev(1'b0, 2);
		rd(OFS_T0_LOW, 32'h01);
		rd(OFS_T0_HIGH, 32'h01);
		// Timer 1 auto-reload, gate active low
		wr(OFS_CTRL, 8'h00);
		wr(OFS_T1_HIGH, 8'h80);
		wr(OFS_T1_LOW, 8'hFF);
		wr(OFS_MODE, 8'hE0);
		wr(OFS_CTRL, 8'h40);
		ev(1'b1, 1);
		rd(OFS_T1_LOW, 32'hFF);
		u_dct_pins_model.gate(1'b1, 1'b0);
		ev(1'b1, 1);
		rd(OFS_T1_LOW, 32'h80);
		rd(OFS_T1_HIGH, 32'h80);
		rd(OFS_CTRL, 32'hC0);
		// Interrupt enable, vector acknowledge, software clear
		wr(OFS_CTRL, 8'h80);
		chk({31'h0, irq1}, 32'h0);
		wr(OFS_IRQEN, 8'h02);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq1}, 32'h1);
		ack1 <= 1'b1;
		@(posedge clk_i);
		ack1 <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq1}, 32'h0);
		rd(OFS_CTRL, 32'h00);
		wr(OFS_IRQEN, 8'h01);
		wr(OFS_CTRL, 8'h20);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq0}, 32'h1);
		ack0 <= 1'b1;
		@(posedge clk_i);
		ack0 <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq0}, 32'h0);
		wr(OFS_CTRL, 8'h20);
		repeat (2) @(posedge clk_i);
		wr(OFS_CTRL, 8'h00);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq0}, 32'h0);
		// Split mode: high byte run by timer 1 run, sets timer 1 flag
		wr(OFS_T1_LOW, 8'h00);
		wr(OFS_T0_HIGH, 8'hFE);
		wr(OFS_CLK, 8'h04);
		wr(OFS_MODE, 8'h33);
		wr(OFS_CTRL, 8'h40);
		repeat (4) @(posedge clk_i);
		rdm(OFS_CTRL, 32'hA0, 32'h80);
		rd(OFS_T1_LOW, 32'h00);
		// Split: timer 1 in auto-reload runs, pulses overflow, no flag
		wr(OFS_CTRL, 8'h00);
		wr(OFS_T1_HIGH, 8'hFC);
		wr(OFS_T1_LOW, 8'hFC);
		wr(OFS_CLK, 8'h0C);
		ovf_base = t1_ovf_seen;
		wr(OFS_MODE, 8'h23);
		repeat (12) @(posedge clk_i);
		chk({31'h0, (t1_ovf_seen - ovf_base) >= 2}, 32'h1);
		rdm(OFS_CTRL, 32'h80, 32'h00);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
